/* File: pcc_top.sv */
/*
  configuration and status registers for the system-clock loop: mode,
  pre-divider range, squarer, split feedback divider, lock status,
  reference oscillator calibration, and event interrupts.
  assumes an apb master in the clock domain, and lock and clock-valid
  levels from the analog loop already synchronous to clock.
  read data is loaded in the setup cycle and pready is always high, so
  every access completes with no wait state.
*/
`timescale 1ns/1ps

// Behaviour
// R1 - loop mode in bits 7:6 resets to 00, which is bypass with the loop off.
// R2 - loop mode 01 enables the loop at a fixed multiple of the master clock.
// R3 - loop mode 10 enables sample-rate tracking; 11 is reserved for software.
// R4 - bit 4 of loop control enables the master-clock squarer, reset 0.
// R5 - input range bits 2:0 reset to 100 and select the master clock band.
// R6 - software must not write range codes 101 to 111.
// R7 - upper fraction is a five-bit field in bits 4:0, reset zero.
// R8 - lower fraction is an eight-bit field in bits 7:0, reset zero.
// R9 - writing the integer register loads all three divider fields at once.
// R10 - status shows clock valid, loop lock, active and tracking lock bits.
// R11 - calibration enable bit 7, start bit 6, trim result in bits 4:0.
// R12 - the divide ratio is a seven-bit integer and thirteen-bit fraction.
module pcc_top
  import pcc_pkg::*;
#(
  parameter int CAL_RUN = CAL_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog loop status inputs
  input wire logic mclkValid,
  input wire logic loopLocked,
  input wire logic trackLocked,
  input wire logic [TRIM_W-1:0] measuredTrim,
  // loop configuration outputs
  output logic loopEnable,
  output logic trackEnable,
  output logic squarerEnable,
  output logic [2:0] inputRange,
  output logic [INTEGER_W-1:0] activeInteger,
  output logic [FRAC_UPPER_W+FRAC_LOWER_W-1:0] activeFraction,
  output logic divLoad,
  output logic calEnable,
  output logic [TRIM_W-1:0] oscTrim,
  // interrupt
  output logic irq
);
  // software registers
  logic [1:0] mode;
  logic squarer;
  logic [2:0] range;
  logic [FRAC_UPPER_W-1:0] fracUpper;
  logic [FRAC_LOWER_W-1:0] fracLower;
  logic [INTEGER_W-1:0] intPart;
  logic calEn;
  logic [IRQ_W-1:0] irqMask;
  logic [IRQ_W-1:0] irqStatus;
  logic lockSeen;
  logic calBusy;
  logic calDone;

  // bus decode, always ready in the access cycle
  wire access = psel && penable;
  wire wrStrobe = access && pwrite;
  wire [9:0] wordIdx = paddr[11:2];
  wire aligned = (paddr[1:0] == 2'b00);

  function automatic logic hit(input logic [9:0] idx,
                               input logic [7:0] target);
    hit = (idx == {2'b00, target});
  endfunction : hit

  // register map by word index, byte address four times it:
  // loop control: mode, squarer, input range
  // fraction upper: five staged upper fraction bits
  // fraction lower: eight staged lower fraction bits
  // integer: seven integer bits, loads the active divider
  // lock status: read only, live view of the loop
  // oscillator cal: enable, start or busy, trim result
  // event status: sticky events, write one to clear
  // event mask: which events drive irq
  // active divider: read only, integer in 22:16, fraction in 12:0
  // one address compare per register, in the order of the map above
  localparam int NUM_REGS = 9;
  localparam logic [7:0] REG_IDX [NUM_REGS] = '{
    IDX_LOOP_CONTROL, IDX_FRAC_UPPER, IDX_FRAC_LOWER, IDX_FB_INTEGER,
    IDX_LOCK_STATUS, IDX_OSC_CAL, IDX_IRQ_STATUS, IDX_IRQ_MASK,
    IDX_ACTIVE_DIV
  };
  logic [NUM_REGS-1:0] hitVec;
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : gen_hit
      assign hitVec[g] = aligned && hit(wordIdx, REG_IDX[g]);
    end
  endgenerate

  wire hitCtrl = hitVec[0];
  wire hitUpper = hitVec[1];
  wire hitLower = hitVec[2];
  wire hitInt = hitVec[3];
  wire hitStat = hitVec[4];
  wire hitCal = hitVec[5];
  wire hitIrqSt = hitVec[6];
  wire hitIrqMk = hitVec[7];
  wire hitActive = hitVec[8];
  wire mapped = |hitVec;
  // writes to the read-only status and divider view are refused
  wire readOnly = hitStat || hitActive;

  // per-register write strobes; refused writes never reach a register
  wire wrUpper = wrStrobe && hitUpper;
  wire wrLower = wrStrobe && hitLower;
  wire wrCal = wrStrobe && hitCal;
  wire wrIrqSt = wrStrobe && hitIrqSt;
  wire wrIrqMk = wrStrobe && hitIrqMk;
  // reads are captured in the setup cycle, so prdata stands in the access
  wire rdSetup = psel && !penable && !pwrite;

  // reserved mode and range codes are kept as written but flagged,
  // so software sees its mistake as an event rather than a lost write
  wire badMode = (pwdata[MODE_HI:MODE_LO] == 2'(PCC_RESERVED)); // see R3
  wire badRange = (pwdata[RANGE_HI:RANGE_LO] > RANGE_RESET); // see R6
  wire ctrlWrite = wrStrobe && hitCtrl;
  wire intWrite = wrStrobe && hitInt;
  wire calStart = wrCal && pwdata[CAL_START_BIT]; // see R11
  // writing enable and start together starts at once, and writing enable
  // low aborts a run in that same cycle
  wire calEnNow = wrCal ? pwdata[CAL_EN_BIT] : calEn; // see R11

  assign pready = 1'b1;
  assign pslverr = access && (!mapped || (pwrite && readOnly));

  // decoded mode drives the loop
  // reserved mode 11 is stored as written, but the loop stays off
  pcc_mode_t modeSel;
  assign modeSel = pcc_mode_t'(mode);
  assign loopEnable = (modeSel == PCC_NORMAL) || (modeSel == PCC_TRACK); // see R2
  assign trackEnable = (modeSel == PCC_TRACK); // see R3
  assign squarerEnable = squarer; // see R4
  assign inputRange = range; // see R5
  assign calEnable = calEn;

  // status byte from the loop's own state
  // lock bits read 0 while the loop is off, whatever the analog side says
  logic [7:0] statusByte;
  always_comb begin
    statusByte = 8'h00;
    statusByte[ST_MCLK_VALID] = mclkValid; // see R10
    statusByte[ST_LOOP_LOCK] = loopEnable && loopLocked; // see R10
    statusByte[ST_ACTIVE] = loopEnable; // see R10
    statusByte[ST_TRACK_LOCK] = trackEnable && trackLocked; // see R10
  end

  // lock events for the interrupt block
  // lockSeen starts low, as the lock bit does, so reset makes no edge
  wire lockNow = statusByte[ST_LOOP_LOCK];
  logic [IRQ_W-1:0] events;
  always_comb begin
    events = '0;
    events[IRQ_LOCK_GAIN] = lockNow && !lockSeen;
    events[IRQ_LOCK_LOSS] = !lockNow && lockSeen;
    events[IRQ_CAL_DONE] = calDone;
    events[IRQ_BAD_CODE] = ctrlWrite && (badMode || badRange);
  end

  wire [IRQ_W-1:0] clearOnes =
    wrIrqSt ? pwdata[IRQ_W-1:0] : '0;

  // read data mux
  logic [31:0] readMux;
  always_comb begin
    readMux = 32'h0000_0000;
    if (hitCtrl) begin
      readMux[MODE_HI:MODE_LO] = mode;
      readMux[SQUARER_BIT] = squarer;
      readMux[RANGE_HI:RANGE_LO] = range;
    end
    if (hitUpper) readMux[FRAC_UPPER_W-1:0] = fracUpper;
    if (hitLower) readMux[FRAC_LOWER_W-1:0] = fracLower;
    if (hitInt) readMux[INTEGER_W-1:0] = intPart;
    if (hitStat) readMux[7:0] = statusByte;
    if (hitCal) begin
      readMux[CAL_EN_BIT] = calEn;
      readMux[CAL_START_BIT] = calBusy; // start reads high while running
      readMux[TRIM_W-1:0] = oscTrim; // see R11
    end
    if (hitIrqSt) readMux[IRQ_W-1:0] = irqStatus;
    if (hitIrqMk) readMux[IRQ_W-1:0] = irqMask;
    if (hitActive) begin
      readMux[FRAC_UPPER_W+FRAC_LOWER_W-1:0] = activeFraction;
      readMux[INTEGER_W+15:16] = activeInteger;
    end
  end

  // read data register, loaded in the setup cycle, held through the access
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rdSetup) begin
      prdata <= readMux;
    end
  end

  // loop control register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode <= MODE_RESET; // see R1
      squarer <= SQUARER_RESET; // see R4
      range <= RANGE_RESET; // see R5
    end else if (ctrlWrite) begin
      mode <= pwdata[MODE_HI:MODE_LO];
      squarer <= pwdata[SQUARER_BIT];
      range <= pwdata[RANGE_HI:RANGE_LO];
    end
  end

  // staged divider fields
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fracUpper <= FRAC_UPPER_RESET; // see R7
      fracLower <= FRAC_LOWER_RESET; // see R8
      intPart <= INTEGER_RESET;
    end else begin
      if (wrUpper) fracUpper <= pwdata[FRAC_UPPER_W-1:0]; // see R7
      if (wrLower) fracLower <= pwdata[FRAC_LOWER_W-1:0]; // see R8
      if (intWrite) intPart <= pwdata[INTEGER_W-1:0];
    end
  end

  // active divider, loaded all together on an integer write
  // fraction writes only stage, so the loop never sees a ratio that is
  // half old and half new
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      activeInteger <= INTEGER_RESET;
      activeFraction <= {FRAC_UPPER_RESET, FRAC_LOWER_RESET};
      divLoad <= 1'b0;
    end else begin
      divLoad <= intWrite; // see R9
      if (intWrite) begin
        activeInteger <= pwdata[INTEGER_W-1:0]; // see R9
        activeFraction <= {fracUpper, fracLower}; // see R12
      end
    end
  end

  // calibration enable, mask and lock history
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      calEn <= 1'b0;
      irqMask <= '0;
      lockSeen <= 1'b0;
    end else begin
      if (wrCal) calEn <= pwdata[CAL_EN_BIT]; // see R11
      if (wrIrqMk) irqMask <= pwdata[IRQ_W-1:0];
      lockSeen <= lockNow;
    end
  end

  // calibration sequencer
  // it sees the enable being written, so a combined enable-and-start
  // write is not lost to the one-cycle lag of the enable register
  pcc_osc_cal #(
    .RUN_CYCLES(CAL_RUN)
  ) calUnit (
    .clock(clock),
    .rst(rst),
    .enable(calEnNow),
    .start(calStart),
    .measuredTrim(measuredTrim),
    .trim(oscTrim),
    .busy(calBusy),
    .done(calDone)
  );

  // event flags and interrupt
  // an event and its clear in one cycle leave the bit set
  pcc_sticky #(
    .WIDTH(IRQ_W)
  ) irqUnit (
    .clock(clock),
    .rst(rst),
    .event_in(events),
    .clearOnes(clearOnes),
    .mask(irqMask),
    .status(irqStatus),
    .irq(irq)
  );
endmodule : pcc_top

/* File: pcc_pkg.sv */
/*
  package for the loop clock configuration block: register offsets, field
  positions, reset values, mode and range codes, timing counts.
  assumes an apb slave with 32-bit data and byte addresses.
*/
package pcc_pkg;
  // printed offsets are not multiples of four: they are word indices
  localparam logic [7:0] IDX_LOOP_CONTROL = 8'h91;
  localparam logic [7:0] IDX_FRAC_UPPER = 8'h92;
  localparam logic [7:0] IDX_FRAC_LOWER = 8'h93;
  localparam logic [7:0] IDX_FB_INTEGER = 8'h94;
  localparam logic [7:0] IDX_LOCK_STATUS = 8'h95;
  localparam logic [7:0] IDX_OSC_CAL = 8'h98;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'ha0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'ha1;
  localparam logic [7:0] IDX_ACTIVE_DIV = 8'ha2;

  // loop control fields
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int SQUARER_BIT = 4;
  localparam int RANGE_HI = 2;
  localparam int RANGE_LO = 0;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic SQUARER_RESET = 1'b0;
  localparam logic [2:0] RANGE_RESET = 3'h4;

  // divider fields
  localparam int FRAC_UPPER_W = 5;
  localparam int FRAC_LOWER_W = 8;
  localparam int INTEGER_W = 7;
  localparam logic [4:0] FRAC_UPPER_RESET = 5'h00;
  localparam logic [7:0] FRAC_LOWER_RESET = 8'h00;
  localparam logic [6:0] INTEGER_RESET = 7'h20;

  // status bit positions
  localparam int ST_MCLK_VALID = 0;
  localparam int ST_LOOP_LOCK = 3;
  localparam int ST_ACTIVE = 4;
  localparam int ST_TRACK_LOCK = 7;

  // calibration fields
  localparam int CAL_EN_BIT = 7;
  localparam int CAL_START_BIT = 6;
  localparam int TRIM_W = 5;
  localparam logic [4:0] TRIM_RESET = 5'h00;

  // interrupt bits
  localparam int IRQ_LOCK_GAIN = 0;
  localparam int IRQ_LOCK_LOSS = 1;
  localparam int IRQ_CAL_DONE = 2;
  localparam int IRQ_BAD_CODE = 3;
  localparam int IRQ_W = 4;

  // timing
  localparam int CLK_MHZ = 100;
  localparam int CAL_TIME_US = 10;
  localparam int CAL_CYCLES = CAL_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    PCC_BYPASS,
    PCC_NORMAL,
    PCC_TRACK,
    PCC_RESERVED
  } pcc_mode_t;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_RUN,
    CAL_DONE
  } pcc_cal_state_t;
endpackage : pcc_pkg

/* File: pcc_sticky.sv */
/*
  sticky event bits with write-one-to-clear and a mask gating one level
  interrupt output.
  assumes events are one-cycle pulses in the clock domain.
*/
`timescale 1ns/1ps
module pcc_sticky
  import pcc_pkg::*;
#(
  parameter int WIDTH = IRQ_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // events and software access
  input wire logic [WIDTH-1:0] event_in,
  input wire logic [WIDTH-1:0] clearOnes,
  input wire logic [WIDTH-1:0] mask,
  // state
  output logic [WIDTH-1:0] status,
  output logic irq
);
  logic [WIDTH-1:0] next_status;

  // set wins over a clear in the same cycle
  assign next_status = (status & ~clearOnes) | event_in;
  assign irq = |(status & mask);

  // sticky storage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end
endmodule : pcc_sticky

/* File: pcc_osc_cal.sv */
/*
  reference oscillator calibration sequencer: on a start pulse while
  enabled, runs for a fixed time and then latches a trim value.
  assumes the measured trim arrives as a level input from the analog side.
*/
`timescale 1ns/1ps
module pcc_osc_cal
  import pcc_pkg::*;
#(
  parameter int RUN_CYCLES = CAL_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic enable,
  input wire logic start,
  input wire logic [TRIM_W-1:0] measuredTrim,
  // results
  output logic [TRIM_W-1:0] trim,
  output logic busy,
  output logic done
);
  pcc_cal_state_t state;
  pcc_cal_state_t next_state;
  logic [15:0] count;
  wire lastCycle = (count == 16'(RUN_CYCLES - 1));

  // sequencing
  always_comb begin
    next_state = state;
    case (state)
      CAL_IDLE: begin
        if (enable && start) next_state = CAL_RUN;
      end
      CAL_RUN: begin
        if (!enable) next_state = CAL_IDLE;
        else if (lastCycle) next_state = CAL_DONE;
      end
      CAL_DONE: next_state = CAL_IDLE;
      default: next_state = CAL_IDLE;
    endcase
  end

  assign busy = (state == CAL_RUN);
  assign done = (state == CAL_DONE);

  // state, run counter and trim result
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= CAL_IDLE;
      count <= '0;
      trim <= TRIM_RESET;
    end else begin
      state <= next_state;
      count <= (state == CAL_RUN) ? count + 16'h0001 : 16'h0000;
      if (state == CAL_RUN && lastCycle) trim <= measuredTrim;
    end
  end
endmodule : pcc_osc_cal

/* File: pcc_sva.sv */
/* pcc_sva: assertions on the ports of pcc_top.
   assumes one clock domain and zero-wait apb accesses. */
`timescale 1ns/1ps
module pcc_sva
  import pcc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // loop outputs
  input wire logic loopEnable,
  input wire logic trackEnable,
  input wire logic squarerEnable,
  input wire logic [2:0] inputRange,
  input wire logic [INTEGER_W-1:0] activeInteger,
  input wire logic [FRAC_UPPER_W+FRAC_LOWER_W-1:0] activeFraction,
  input wire logic divLoad
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  // accepted writes to loop control and to the integer divider
  sequence wrCtl;
    psel && penable && pwrite && paddr == 12'h244;
  endsequence
  sequence wrInt;
    psel && penable && pwrite && paddr == 12'h250;
  endsequence
  chk_loop_mode: assert property (
    wrCtl |=> loopEnable == ^$past(pwdata[7:6]))
    else $error("loop enable does not follow mode");
  chk_track_mode: assert property (
    wrCtl |=> trackEnable == ($past(pwdata[7:6]) == 2'h2))
    else $error("track enable does not follow mode");
  chk_squarer_bit: assert property (
    wrCtl |=> squarerEnable == $past(pwdata[4]))
    else $error("squarer enable wrong");
  chk_range_field: assert property (
    wrCtl |=> inputRange == $past(pwdata[2:0]))
    else $error("input range wrong");
  chk_div_pulse: assert property (
    wrInt |=> divLoad ##1 !divLoad)
    else $error("divider load pulse missing");
  chk_div_cause: assert property (
    divLoad |-> $past(psel && penable && pwrite && paddr == 12'h250))
    else $error("divider load without integer write");
  chk_int_load: assert property (
    wrInt |=> activeInteger == $past(pwdata[6:0]))
    else $error("active integer wrong");
  chk_frac_hold: assert property (
    !divLoad |-> $stable(activeFraction))
    else $error("active fraction changed without load");
endmodule : pcc_sva

/* File: pcc_clk_source.sv */
/* pcc_clk_source: master clock and word clock side of the loop.
   assumes it sees the loop enables of pcc_top. */
`timescale 1ns/1ps
module pcc_clk_source #(
  parameter int LOCK_DLY = 4,
  parameter logic [4:0] TRIM = 5'h13
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // loop requests
  input wire logic loopEnable,
  input wire logic trackEnable,
  // analog status
  output logic mclkValid,
  output logic loopLocked,
  output logic trackLocked,
  output logic [4:0] measuredTrim
);
  logic [3:0] lockCount;
  // clock present and trim measured once out of reset
  assign mclkValid = !rst;
  assign measuredTrim = TRIM;
  // loop settles a few cycles after it is enabled
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lockCount <= 4'h0;
    end else if (!loopEnable) begin
      lockCount <= 4'h0;
    end else if (lockCount != 4'(LOCK_DLY)) begin
      lockCount <= lockCount + 4'h1;
    end
  end
  // lock flags
  assign loopLocked = lockCount == 4'(LOCK_DLY);
  assign trackLocked = loopLocked && trackEnable;
endmodule : pcc_clk_source

/* File: pcc_top_bench.sv */
/* pcc_top_bench: register tests of pcc_top over apb.
   assumes the clock source model pcc_clk_source. */
`timescale 1ns/1ps
module pcc_top_bench
  import pcc_pkg::*;
;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic mclkValid, loopLocked, trackLocked, loopEnable, trackEnable;
  logic squarerEnable, divLoad, calEnable;
  logic [4:0] measuredTrim, oscTrim;
  logic [2:0] inputRange;
  logic [6:0] activeInteger;
  logic [12:0] activeFraction;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  // clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  pcc_top #(.CAL_RUN(8)) uut (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mclkValid(mclkValid), .loopLocked(loopLocked),
    .trackLocked(trackLocked), .measuredTrim(measuredTrim),
    .loopEnable(loopEnable), .trackEnable(trackEnable),
    .squarerEnable(squarerEnable), .inputRange(inputRange),
    .activeInteger(activeInteger), .activeFraction(activeFraction),
    .divLoad(divLoad), .calEnable(calEnable), .oscTrim(oscTrim), .irq(irq));
  pcc_clk_source src (.clock(clock), .rst(rst), .loopEnable(loopEnable),
    .trackEnable(trackEnable), .mclkValid(mclkValid),
    .loopLocked(loopLocked), .trackLocked(trackLocked),
    .measuredTrim(measuredTrim));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one apb transfer; response and read data are taken at the access edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    @(negedge clock); // outputs launched by the write settle first
  endtask : wr
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  // hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  // main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rdchk(12'h244, 32'h4);
    rdchk(12'h248, 32'h0);
    rdchk(12'h24c, 32'h0);
    wr(12'h248, 32'hff);
    rdchk(12'h248, 32'h1f);
    wr(12'h24c, 32'ha5);
    rdchk(12'h24c, 32'ha5);
    check({19'h0, activeFraction}, 32'h0);
    wr(12'h250, 32'hd3);
    check({25'h0, activeInteger}, 32'h53);
    check({19'h0, activeFraction}, 32'h1fa5);
    rdchk(12'h288, 32'h531fa5);
    for (int m = 0; m < 3; m++) begin
      wr(12'h244, {24'h0, 2'(m), 6'h4});
      repeat (8) @(posedge clock);
      check({trackEnable, loopEnable}, {m == 2, m != 0});
      rdchk(12'h254, {m == 2, 2'h0, m != 0, m != 0, 3'h1});
    end
    for (int r = 0; r < 5; r++) begin // codes above 4 unused
      wr(12'h244, 32'(16 + r));
      check({squarerEnable, 1'b0, inputRange}, 32'(16 + r));
    end
    wr(12'h244, 32'h4);
    check({31'h0, squarerEnable}, 32'h0);
    // reserved mode raises a masked interrupt
    wr(12'h280, 32'hf);
    wr(12'h284, 32'h8);
    wr(12'h244, 32'hc4);
    repeat (2) @(posedge clock);
    check({31'h0, irq}, 32'h1);
    wr(12'h284, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(12'h284, 32'h8);
    wr(12'h280, 32'h8);
    @(posedge clock);
    check({31'h0, irq}, 32'h0);
    // calibration
    wr(12'h280, 32'hf);
    wr(12'h284, 32'h4);
    wr(12'h260, 32'hc0);
    rdchk(12'h260, 32'hc0);
    check({31'h0, calEnable}, 32'h1);
    while (irq !== 1'b1) @(posedge clock);
    check({27'h0, oscTrim}, 32'h13);
    rdchk(12'h260, 32'h93);
    // unmapped address and read-only write are refused
    xfer(1'b0, 12'h2fc, 32'h0);
    check({31'h0, err}, 32'h1);
    wr(12'h254, 32'hff);
    check({31'h0, err}, 32'h1);
    complete_run();
  end
endmodule : pcc_top_bench
bind pcc_top pcc_sva chk (.clock(clock), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .loopEnable(loopEnable), .trackEnable(trackEnable),
  .squarerEnable(squarerEnable), .inputRange(inputRange),
  .activeInteger(activeInteger), .activeFraction(activeFraction),
  .divLoad(divLoad));
